// ### analog_inputs_model.sv
// Purpose: stand-in for the analog levels on both comparator inputs
// Assumes: levels are 8-bit codes, equal levels never offered
// Notes:   one edge of settling mimics a slow comparator core
`timescale 1ns/1ps
module analog_inputs_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] firstPlus,
  input  wire logic [7:0] firstMinus,
  input  wire logic [7:0] secondPlus,
  input  wire logic [7:0] secondMinus,
  output logic            firstRawResult,
  output logic            secondRawResult
);
  // high only while non-inverting is above inverting
  always_ff @(posedge clk_sys)
  begin
    firstRawResult  <= firstPlus > firstMinus;
    secondRawResult <= secondPlus > secondMinus;
  end
endmodule

// ### cmp_ctrl_pkg.sv
// Purpose: shared constants and types for the dual comparator control block
// Assumes: AXI4-Lite, 32-bit data, byte registers in the low bits of a word
// Notes:   register byte addresses are four times the printed register index
package cmp_ctrl_pkg;

  // ************************************************************
  // register indices and bus address width
  // ************************************************************
  localparam logic [7:0] IDX_PORT_A_PINS   = 8'h05;
  localparam logic [7:0] IDX_CORE_INT      = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS2 = 8'h0d;
  localparam logic [7:0] IDX_PORT_A_DIR    = 8'h85;
  localparam logic [7:0] IDX_PERIPH_EN2    = 8'h8d;
  localparam logic [7:0] IDX_CMP_CTRL      = 8'h9c;
  localparam logic [7:0] IDX_VREF_CTRL     = 8'h9d;
  localparam int         ADDR_W            = 10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_CMP_CTRL      = 8'h07;
  localparam logic [5:0] RST_PORT_A_DIR    = 6'h3f;
  localparam logic [7:0] RST_ZERO          = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_SECOND_RESULT  = 7;
  localparam int BIT_FIRST_RESULT   = 6;
  localparam int BIT_SECOND_INVERT  = 5;
  localparam int BIT_FIRST_INVERT   = 4;
  localparam int BIT_INPUT_SWITCH   = 3;
  localparam int BIT_CHANGE_FLAG    = 6;
  localparam int BIT_CHANGE_ENABLE  = 6;
  localparam int BIT_GLOBAL_IRQ     = 7;
  localparam int BIT_PERIPH_IRQ     = 6;
  localparam logic [7:0] MASK_VREF  = 8'hef;
  localparam logic [7:0] MASK_FLAGS2 = 8'h4f;

  // ************************************************************
  // comparator modes
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_RESET_ANALOG = 3'b000,
    MODE_ONE_INDEP    = 3'b001,
    MODE_TWO_INDEP    = 3'b010,
    MODE_TWO_COMMON   = 3'b011,
    MODE_TWO_COMM_OUT = 3'b100,
    MODE_ONE_OUT      = 3'b101,
    MODE_FOUR_MUX     = 3'b110,
    MODE_OFF          = 3'b111
  } cmp_mode_t;

  // routing decode of one mode
  typedef struct packed {
    logic [3:0] analogPins;  // port pins 3..0 held analog
    logic       firstOn;
    logic       secondOn;
    logic       firstRouted;  // first result drives output pin one
    logic       secondRouted; // second result drives output pin two
    logic       useInternalRef;
  } route_t;

endpackage

// ### dual_comparator_control.sv
// Purpose: register, routing and change-flag logic around two comparators
// Assumes: raw comparator results arrive asynchronously from the analog cores
// Notes:   AXI4-Lite slave, one write and one read outstanding at a time
`timescale 1ns/1ps

// What this block does
// - eight modes chosen by a three-bit mode field in the control register
// - raw result low when non-inverting input below inverting, high when above
// - mode 110 connects internal reference to both non-inverting inputs
// - both outputs readable in control register, writes there change nothing
// - mode 100 drives both output pins, mode 101 only pin two, straight from comparators
// - direction bits still act as output enable on routed pins
// - two control bits invert each comparator output independently
// - port reads return zero for pins held as analog inputs
// - flag sets when either output differs from last latched value
// - flag cleared only by writing zero, writing one sets it
// - interrupt needs all three enables, flag sets regardless
// - control register access ends mismatch, mismatch keeps setting flag
// - change coinciding with a control read still sets the flag
// - comparators keep running in sleep and their interrupt wakes device
// - wake-up from sleep leaves control register unchanged
// - any reset returns control register to 0x07, off mode
// - direction register governs comparator pin direction in every mode
// - mode 110 input switch picks pins 3/2 when set, 0/1 when clear
// - inversion applies before status bit and before routed pin
module dual_comparator_control (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        firstRawResult,
  input  wire logic        secondRawResult,
  input  wire logic [5:0]  portPinIn,
  output logic [5:0]       portPinOut,
  output logic [5:0]       portPinOe_n,
  output logic             firstCmpEnable,
  output logic             secondCmpEnable,
  output logic [1:0]       firstInvertingSel,
  output logic [1:0]       secondInvertingSel,
  output logic             internalRefSelect,
  output logic [7:0]       voltageRefControl,
  output logic             comparatorIrq,
  output logic             wakeRequest
);

  // ************************************************************
  // routing table
  // ************************************************************
  // one table shared by pin logic and port reads
  function automatic cmp_ctrl_pkg::route_t decode_mode(input logic [2:0] m);
    cmp_ctrl_pkg::route_t r;
    r = '0;
    unique case (cmp_ctrl_pkg::cmp_mode_t'(m))
      cmp_ctrl_pkg::MODE_RESET_ANALOG: r = '{4'hf, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      cmp_ctrl_pkg::MODE_ONE_INDEP:    r = '{4'h7, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      cmp_ctrl_pkg::MODE_TWO_INDEP:    r = '{4'hf, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      cmp_ctrl_pkg::MODE_TWO_COMMON:   r = '{4'h7, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      cmp_ctrl_pkg::MODE_TWO_COMM_OUT: r = '{4'h7, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      cmp_ctrl_pkg::MODE_ONE_OUT:      r = '{4'hc, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      cmp_ctrl_pkg::MODE_FOUR_MUX:     r = '{4'hf, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      cmp_ctrl_pkg::MODE_OFF:          r = '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    return r;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic [2:0] modeField_ff;
  logic       inputSwitchSelect_ff;
  logic       firstOutputInvert_ff;
  logic       secondOutputInvert_ff;
  logic [5:0] portLatch_ff;
  logic [5:0] portDirection_ff;
  logic [7:0] coreIrq_ff;
  logic [7:0] flagsTwo_ff;
  logic [7:0] enablesTwo_ff;
  logic [7:0] vrefCtrl_ff;
  logic [1:0] rawSync1_ff;
  logic [1:0] rawSync2_ff;
  logic [1:0] latchedOut_ff;
  logic [5:0] pinSync1_ff;
  logic [5:0] pinSync2_ff;
  logic       awHeld_ff;
  logic       wHeld_ff;
  logic [7:0] awIdx_ff;
  logic [7:0] wByte_ff;
  logic       bvalid_ff;
  logic       rvalid_ff;
  logic [7:0] rdata_ff;
  logic       rSlvErr_ff;
  logic       bSlvErr_ff;

  cmp_ctrl_pkg::route_t route;
  logic [1:0]           resultNow;
  logic [1:0]           resultAsync;
  logic                 writeFire;
  logic                 readFire;
  logic [7:0]           rdIdx;
  logic                 cmpAccess;
  logic                 mismatch;
  logic [7:0]           cmpCtrlView;
  logic [7:0]           nxt_rdata;
  logic                 nxt_rErr;
  logic                 wrCmp;

  assign route = decode_mode(modeField_ff);

  // ************************************************************
  // comparator outputs
  // ************************************************************
  // raw results are high when the non-inverting input is the larger one
  assign resultAsync = {secondRawResult ^ secondOutputInvert_ff,
                        firstRawResult ^ firstOutputInvert_ff};
  // status and flag results pass both flops first; inversion is applied after them
  assign resultNow   = (rawSync2_ff ^ {secondOutputInvert_ff, firstOutputInvert_ff})
                     & {route.secondOn, route.firstOn};

  // analog enables and input muxing; the cores keep running through sleep
  assign firstCmpEnable    = route.firstOn;
  assign secondCmpEnable   = route.secondOn;
  assign internalRefSelect = route.useInternalRef;
  assign voltageRefControl = vrefCtrl_ff;
  always_comb
  begin
    if (route.useInternalRef && inputSwitchSelect_ff)
    begin
      firstInvertingSel  = 2'h3;
      secondInvertingSel = 2'h2;
    end
    else
    begin
      firstInvertingSel  = 2'h0;
      secondInvertingSel = 2'h1;
    end
  end

  // routed pins take the unsynchronised result; direction bits stay the enable
  always_comb
  begin
    portPinOut = portLatch_ff;
    if (route.firstRouted)
      portPinOut[4] = resultAsync[0];
    if (route.secondRouted)
      portPinOut[5] = resultAsync[1];
    portPinOe_n = portDirection_ff;
  end

  // ************************************************************
  // synchronisers
  // ************************************************************
  // results and pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rawSync1_ff <= 2'h0;
      rawSync2_ff <= 2'h0;
      pinSync1_ff <= 6'h00;
      pinSync2_ff <= 6'h00;
    end
    else
    begin
      rawSync1_ff <= {secondRawResult, firstRawResult};
      rawSync2_ff <= rawSync1_ff;
      pinSync1_ff <= portPinIn;
      pinSync2_ff <= pinSync1_ff;
    end
  end

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
  assign writeFire     = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bSlvErr_ff ? 2'b10 : 2'b00;
  assign wrCmp         = writeFire && awIdx_ff == cmp_ctrl_pkg::IDX_CMP_CTRL;

  // address and data captured in either order
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awIdx_ff  <= 8'h00;
      wByte_ff  <= 8'h00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        awIdx_ff  <= s_axi_awaddr[cmp_ctrl_pkg::ADDR_W-1:2];
      end
      else if (writeFire)
        awHeld_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff <= 1'b1;
        // byte lane zero gates the register byte
        wByte_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      else if (writeFire)
        wHeld_ff <= 1'b0;
    end
  end

  // response after both halves; unmapped index answers SLVERR
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bvalid_ff  <= 1'b0;
      bSlvErr_ff <= 1'b0;
    end
    else if (writeFire)
    begin
      bvalid_ff <= 1'b1;
      unique case (awIdx_ff)
        cmp_ctrl_pkg::IDX_PORT_A_PINS, cmp_ctrl_pkg::IDX_CORE_INT,
        cmp_ctrl_pkg::IDX_PERIPH_FLAGS2, cmp_ctrl_pkg::IDX_PORT_A_DIR,
        cmp_ctrl_pkg::IDX_PERIPH_EN2, cmp_ctrl_pkg::IDX_CMP_CTRL,
        cmp_ctrl_pkg::IDX_VREF_CTRL: bSlvErr_ff <= 1'b0;
        default:                     bSlvErr_ff <= 1'b1;
      endcase
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // ************************************************************
  // registers
  // ************************************************************
  // a write-strobe of zero still counts, the byte is taken as zero
  // sleep has no path here, so control contents survive wake-up
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      modeField_ff          <= cmp_ctrl_pkg::RST_CMP_CTRL[2:0];
      inputSwitchSelect_ff  <= 1'b0;
      firstOutputInvert_ff  <= 1'b0;
      secondOutputInvert_ff <= 1'b0;
    end
    else if (wrCmp)
    begin
      // result bits are not storage, writes there are dropped
      modeField_ff          <= wByte_ff[2:0];
      inputSwitchSelect_ff  <= wByte_ff[cmp_ctrl_pkg::BIT_INPUT_SWITCH];
      firstOutputInvert_ff  <= wByte_ff[cmp_ctrl_pkg::BIT_FIRST_INVERT];
      secondOutputInvert_ff <= wByte_ff[cmp_ctrl_pkg::BIT_SECOND_INVERT];
    end
  end

  // port, direction, interrupt control and reference registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      portLatch_ff     <= 6'h00;
      portDirection_ff <= cmp_ctrl_pkg::RST_PORT_A_DIR;
      coreIrq_ff       <= cmp_ctrl_pkg::RST_ZERO;
      enablesTwo_ff    <= cmp_ctrl_pkg::RST_ZERO;
      vrefCtrl_ff      <= cmp_ctrl_pkg::RST_ZERO;
    end
    else if (writeFire)
    begin
      unique case (awIdx_ff)
        cmp_ctrl_pkg::IDX_PORT_A_PINS: portLatch_ff     <= wByte_ff[5:0];
        cmp_ctrl_pkg::IDX_PORT_A_DIR:  portDirection_ff <= wByte_ff[5:0];
        cmp_ctrl_pkg::IDX_CORE_INT:    coreIrq_ff       <= wByte_ff;
        cmp_ctrl_pkg::IDX_PERIPH_EN2:  enablesTwo_ff    <= wByte_ff & cmp_ctrl_pkg::MASK_FLAGS2;
        cmp_ctrl_pkg::IDX_VREF_CTRL:   vrefCtrl_ff      <= wByte_ff & cmp_ctrl_pkg::MASK_VREF;
        default:                       ;
      endcase
    end
  end

  // ************************************************************
  // change detection and flag
  // ************************************************************
  assign cmpAccess = wrCmp || (readFire && rdIdx == cmp_ctrl_pkg::IDX_CMP_CTRL);
  assign mismatch  = resultNow != latchedOut_ff;

  // any control access relatches the outputs and ends the mismatch
  // a change in the access cycle itself is latched, but its mismatch still sets the flag
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      latchedOut_ff <= 2'h0;
    else if (cmpAccess)
      latchedOut_ff <= resultNow;
  end

  // a standing mismatch beats a software clear of the flag
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      flagsTwo_ff <= cmp_ctrl_pkg::RST_ZERO;
    else
    begin
      if (writeFire && awIdx_ff == cmp_ctrl_pkg::IDX_PERIPH_FLAGS2)
        flagsTwo_ff <= wByte_ff & cmp_ctrl_pkg::MASK_FLAGS2;
      if (mismatch)
        flagsTwo_ff[cmp_ctrl_pkg::BIT_CHANGE_FLAG] <= 1'b1;
    end
  end

  // flag always sets; the line needs all three enables
  assign comparatorIrq = flagsTwo_ff[cmp_ctrl_pkg::BIT_CHANGE_FLAG]
                       && enablesTwo_ff[cmp_ctrl_pkg::BIT_CHANGE_ENABLE]
                       && coreIrq_ff[cmp_ctrl_pkg::BIT_PERIPH_IRQ]
                       && coreIrq_ff[cmp_ctrl_pkg::BIT_GLOBAL_IRQ];
  // wake ignores the global enable, as a sleeping core would
  assign wakeRequest = flagsTwo_ff[cmp_ctrl_pkg::BIT_CHANGE_FLAG]
                     && enablesTwo_ff[cmp_ctrl_pkg::BIT_CHANGE_ENABLE];

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  assign s_axi_arready = !rvalid_ff;
  assign readFire      = s_axi_arvalid && s_axi_arready;
  assign rdIdx         = s_axi_araddr[cmp_ctrl_pkg::ADDR_W-1:2];
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = {24'h000000, rdata_ff};
  assign s_axi_rresp   = rSlvErr_ff ? 2'b10 : 2'b00;
  assign cmpCtrlView   = {resultNow[1], resultNow[0], secondOutputInvert_ff,
                          firstOutputInvert_ff, inputSwitchSelect_ff, modeField_ff};

  // read mux; analog pins read as zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    nxt_rErr  = 1'b0;
    unique case (rdIdx)
      cmp_ctrl_pkg::IDX_PORT_A_PINS:   nxt_rdata = {2'b00, pinSync2_ff[5:4],
                                                    pinSync2_ff[3:0] & ~route.analogPins};
      cmp_ctrl_pkg::IDX_CORE_INT:      nxt_rdata = coreIrq_ff;
      cmp_ctrl_pkg::IDX_PERIPH_FLAGS2: nxt_rdata = flagsTwo_ff;
      cmp_ctrl_pkg::IDX_PORT_A_DIR:    nxt_rdata = {2'b00, portDirection_ff};
      cmp_ctrl_pkg::IDX_PERIPH_EN2:    nxt_rdata = enablesTwo_ff;
      cmp_ctrl_pkg::IDX_CMP_CTRL:      nxt_rdata = cmpCtrlView;
      cmp_ctrl_pkg::IDX_VREF_CTRL:     nxt_rdata = vrefCtrl_ff;
      default:                         nxt_rErr  = 1'b1;
    endcase
  end

  // data captured at the address edge, held until rready
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 8'h00;
      rSlvErr_ff <= 1'b0;
    end
    else if (readFire)
    begin
      rvalid_ff  <= 1'b1;
      rdata_ff   <= nxt_rdata;
      rSlvErr_ff <= nxt_rErr;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

endmodule

// ### dual_comparator_control_asserts.sv
// Purpose: port-level checks of the comparator control block
// Assumes: one clock, synchronous active-high reset
// Notes:   the write answer lands two edges after the take
`timescale 1ns/1ps
module dual_comparator_control_asserts (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [5:0]  portPinOe_n,
  input wire logic        firstCmpEnable,
  input wire logic        secondCmpEnable,
  input wire logic [1:0]  firstInvertingSel,
  input wire logic [1:0]  secondInvertingSel,
  input wire logic        internalRefSelect,
  input wire logic        comparatorIrq,
  input wire logic        wakeRequest
);
  // ************************************************************
  // bus handshakes and control relations
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // both write halves offered together by our master
  sequence writeTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (writeTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_read_answer: assert property (readTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_busy_refuses: assert property ((s_axi_rvalid |-> !s_axi_arready) and
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready))
    else $error("request taken while answer pending");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_irq_gated: assert property (comparatorIrq |-> wakeRequest)
    else $error("interrupt without enabled flag");
  a_reset_state: assert property ($fell(reset) |-> portPinOe_n == 6'h3f &&
    !comparatorIrq && !internalRefSelect && !firstCmpEnable && !secondCmpEnable)
    else $error("state after reset not off mode");
  a_ref_both_on: assert property (internalRefSelect |-> firstCmpEnable && secondCmpEnable)
    else $error("reference mode with comparator off");
  a_ref_switch: assert property (internalRefSelect |->
    (firstInvertingSel == 2'd3 && secondInvertingSel == 2'd2) ||
    (firstInvertingSel == 2'd0 && secondInvertingSel == 2'd1))
    else $error("input switch pins wrong");
endmodule

bind dual_comparator_control dual_comparator_control_asserts chk (
  .clk_sys, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .portPinOe_n, .firstCmpEnable, .secondCmpEnable,
  .firstInvertingSel, .secondInvertingSel, .internalRefSelect, .comparatorIrq,
  .wakeRequest
);

// ### tb_top.sv
// Purpose: self-checking bench for the dual comparator control block
// Assumes: byte address is four times the register index
// Notes:   bus signals sampled at the falling edge, moved at the rising
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] CTRL = cmp_ctrl_pkg::IDX_CMP_CTRL;
  localparam logic [7:0] FLAGS = cmp_ctrl_pkg::IDX_PERIPH_FLAGS2;
  localparam logic [7:0] ENAB = cmp_ctrl_pkg::IDX_PERIPH_EN2;
  localparam logic [7:0] CORE = cmp_ctrl_pkg::IDX_CORE_INT;
  localparam logic [7:0] DIR = cmp_ctrl_pkg::IDX_PORT_A_DIR;
  localparam logic [7:0] VREF = cmp_ctrl_pkg::IDX_VREF_CTRL;
  logic clk_sys = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rng = 32'd75404;
  logic [1:0] bresp, rresp, firstSel, secondSel;
  logic [5:0] pinIn = 0, pinOut, pinOe_n;
  logic [7:0] fp = 8'h40, fm = 8'h80, sp = 8'h40, sm = 8'h80, d, refCtl;
  logic raw1, raw2, refSel, irq, wake;
  int fails = 0, compares = 0;

  always #10 clk_sys = ~clk_sys;

  analog_inputs_model partner (.clk_sys, .firstPlus(fp), .firstMinus(fm),
    .secondPlus(sp), .secondMinus(sm), .firstRawResult(raw1), .secondRawResult(raw2));

  dual_comparator_control dut (.clk_sys, .reset, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .firstRawResult(raw1), .secondRawResult(raw2),
    .portPinIn(pinIn), .portPinOut(pinOut), .portPinOe_n(pinOe_n),
    .firstCmpEnable(), .secondCmpEnable(), .firstInvertingSel(firstSel),
    .secondInvertingSel(secondSel), .internalRefSelect(refSel),
    .voltageRefControl(refCtl), .comparatorIrq(irq), .wakeRequest(wake));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // control byte seen after a write of mode 100 with given inverts
  function automatic logic [7:0] expCtrl(input logic [1:0] inv, input logic [1:0] raw);
    return {raw ^ inv, inv, 4'b0100};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axiWrite(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge clk_sys);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk_sys);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", er, r);
  endtask

  task automatic axiRead(input logic [7:0] idx, output logic [7:0] v, input logic [1:0] er);
    logic a, b;
    logic [1:0] r;
    @(posedge clk_sys);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk_sys);
      a = arvalid && arready;
      b = rvalid;
      r = rresp;
      v = rdata[7:0];
      @(posedge clk_sys);
      if (a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rresp", er, r);
  endtask

  task automatic rdChk(input string n, input logic [7:0] idx, input logic [7:0] e,
                       input logic [7:0] m);
    logic [7:0] v;
    axiRead(idx, v, 2'b00);
    chk(n, e & m, v & m);
  endtask

  // raw results follow these levels one edge later
  task automatic setLevels(input logic r1, input logic r2);
    fp <= r1 ? 8'hc0 - 8'(rng[20:16]) : 8'h20;
    sp <= r2 ? 8'hd0 : 8'h30 + 8'(rng[28:24]);
  endtask

  task automatic checkResets();
    rdChk("ctrlRst", CTRL, 8'h07, 8'hff);
    rdChk("dirRst", DIR, 8'h3f, 8'h3f);
    rdChk("flagRst", FLAGS, 8'h00, 8'h4f);
    rdChk("enRst", ENAB, 8'h00, 8'h4f);
    rdChk("vrefRst", VREF, 8'h00, 8'hff);
  endtask

  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    pinIn <= 6'h3f;
    checkResets();
    // interrupts stay off while modes change
    for (int m = 0; m < 8; m++)
    begin
      axiWrite(CTRL, 8'(m), 2'b00);
      rdChk("mode", CTRL, 8'(m), 8'h3f);
      if (m == 0) rdChk("analogZero", 8'h05, 8'h00, 8'h0f);
    end
    for (int s = 0; s < 2; s++)
    begin
      axiWrite(CTRL, {4'h0, s[0], 3'b110}, 2'b00);
      chk("refSel", 1, refSel);
      chk("firstSel", s ? 3 : 0, firstSel);
      chk("secondSel", s ? 2 : 1, secondSel);
    end
    // routed mode with random inverts, levels and directions
    for (int i = 0; i < 8; i++)
    begin
      rng = xorshift(rng);
      setLevels(rng[0], rng[1]);
      axiWrite(DIR, {2'b00, rng[13:8]}, 2'b00);
      axiWrite(8'h05, {2'b00, rng[21:16]}, 2'b00);
      axiWrite(CTRL, {2'b11, rng[3:2], 4'b0100}, 2'b00);
      repeat (4) @(posedge clk_sys);
      rdChk("ctrl", CTRL, expCtrl(rng[3:2], rng[1:0]), 8'hff);
      chk("pinOut", rng[1:0] ^ rng[3:2], pinOut[5:4]);
      chk("pinOe", rng[13:8], pinOe_n);
      chk("pinLatch", rng[19:16], pinOut[3:0]);
    end
    // change flag: set, held by mismatch, cleared, forced, masked
    axiWrite(ENAB, 8'h40, 2'b00);
    rdChk("ctrl", CTRL, expCtrl(rng[3:2], rng[1:0]), 8'hff);
    axiWrite(FLAGS, 8'h00, 2'b00);
    rdChk("flagIdle", FLAGS, 8'h00, 8'h40);
    axiWrite(CORE, 8'hc0, 2'b00);
    chk("irqIdle", 0, irq);
    setLevels(~rng[0], rng[1]);
    repeat (5) @(posedge clk_sys);
    chk("irqSet", 1, irq);
    axiWrite(FLAGS, 8'h00, 2'b00);
    rdChk("flagHeld", FLAGS, 8'h40, 8'h40);
    rdChk("ctrl", CTRL, expCtrl(rng[3:2], {rng[1], ~rng[0]}), 8'hff);
    axiWrite(FLAGS, 8'h00, 2'b00);
    rdChk("flagClr", FLAGS, 8'h00, 8'h40);
    axiWrite(FLAGS, 8'h40, 2'b00);
    chk("irqSoft", 1, irq);
    axiWrite(CORE, 8'h40, 2'b00);
    chk("irqMasked", 0, irq);
    chk("wake", 1, wake);
    // reference register and an unmapped place
    rng = xorshift(rng);
    axiWrite(VREF, rng[7:0], 2'b00);
    chk("vrefOut", rng[7:0] & 8'hef, refCtl);
    axiWrite(8'h10, 8'h55, 2'b10);
    axiRead(8'h10, d, 2'b10);
    chk("unmapped", 0, d);
    // second reset in mid-run
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    checkResets();
    chk("oeRst", 6'h3f, pinOe_n);
    print_verdict();
  end
endmodule
